// file: src/phy_regs.sv
// configuration and status register bank of a three-port serial bus phy
`timescale 1ns/1ps
// Function
// - cable power level is a read-only copy of the sense input, shown twice.
// - cable power drop flag sets when the sense input goes low.
// - drop flag clears on reset or write 0; set again if sense still low.
// - 6-bit gap count, updated by register write or config packet.
// - gap count returns to 3fh on reset or two resets without update.
// - writing 1 to bus reset trigger starts a bus reset at once.
// - bus reset trigger clears after hardware or bus reset.
// - initiator flag marks a reset started here; carried into self-id.
// - loop timeout flag sets when tree identification waits too long.
// - loop timeout flag clears on reset or when software writes 0.
// - port count field reads constant 0011b.
// - node address read-only; self-id completion sends register 0 upstream.
// - root indicator clears on any reset, sets when node becomes root.
// - 2-bit core revision is a fixed constant.
// - root request asks for root at next reset; survives bus resets.
// - speed capability reads constant 01b.
// - connect status 1 when connected; connect waits 335 ms, disconnect at once.
module phy_regs
	import phy_regs_pkg::*;
#(
	parameter int NUM_PORTS = 3,
	parameter longint DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter logic [1:0] REVISION = REVISION_DEFAULT
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// phy core events
	input wire logic i_cable_power,
	input wire logic i_bus_reset,
	input wire logic i_reset_by_us,
	input wire logic i_loop_timeout,
	input wire logic i_became_root,
	input wire logic i_selfid_done,
	input wire logic [5:0] i_node_address,
	input wire logic i_cfg_gap_valid,
	input wire logic [5:0] i_cfg_gap,
	input wire logic [NUM_PORTS-1:0] i_port_raw,
	// controls toward the phy core
	output logic o_start_reset,
	output logic o_root_request,
	output logic [5:0] o_gap_count,
	output logic o_initiator,
	output logic [NUM_PORTS-1:0] o_port_connected,
	// unsolicited status transfer of register 0
	output logic o_status_valid,
	output logic [7:0] o_status_data,
	// interrupt
	output logic o_irq
);
	// ****************************************
	// reset synchroniser
	// ****************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	// async assert, sync release
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************
	// access decode
	// ****************************************
	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction

	logic wr_ctrl, wr_stat, wr_clr, wr_en;
	assign wr_ctrl = i_wr && hit(i_addr, ADDR_CTRL);
	assign wr_stat = i_wr && hit(i_addr, ADDR_STAT);
	assign wr_clr = i_wr && hit(i_addr, ADDR_IRQ_CLR);
	assign wr_en = i_wr && hit(i_addr, ADDR_IRQ_EN);

	// ****************************************
	// cable power
	// ****************************************
	logic cpl_q;
	logic cpd_q;
	logic cp_fall;

	// previous sense level, to catch the falling edge
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpl_q <= 1'b1;
		end else begin
			cpl_q <= i_cable_power;
		end
	end

	// one-cycle fall of the sense; cpl_q resets high so a sense already low at reset release counts as a fall
	assign cp_fall = cpl_q && !i_cable_power;

	// drop flag: set wins over a clear, and a clear while still low re-sets it
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpd_q <= 1'b0;
		end else if (cp_fall || (cpd_q && !i_cable_power)) begin
			cpd_q <= 1'b1;
		end else if (wr_stat && !i_wdata[STAT_CPD_BIT]) begin
			cpd_q <= 1'b0;
		end
	end

	// ****************************************
	// gap count
	// ****************************************
	logic [5:0] gap_q;
	logic gap_touched_q;
	logic gap_reset_seen_q;

	// an update arms the count; two bus resets with none between restore it
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= GAP_RESET;
			gap_touched_q <= 1'b0;
			gap_reset_seen_q <= 1'b0;
		end else if (wr_ctrl) begin
			gap_q <= i_wdata[CTRL_GAP_LSB +: 6];
			gap_touched_q <= 1'b1;
			gap_reset_seen_q <= 1'b0;
		end else if (i_cfg_gap_valid) begin
			gap_q <= i_cfg_gap;
			gap_touched_q <= 1'b1;
			gap_reset_seen_q <= 1'b0;
		end else if (i_bus_reset) begin
			if (gap_touched_q) begin
				gap_touched_q <= 1'b0;
				gap_reset_seen_q <= 1'b1;
			end else if (gap_reset_seen_q) begin
				gap_q <= GAP_RESET;
				gap_reset_seen_q <= 1'b0;
			end else begin
				gap_reset_seen_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// bus reset trigger, initiator, root request
	// ****************************************
	logic trig_q;
	logic init_q;
	logic rreq_q;

	// trigger holds until the bus reset it asked for is seen
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_q <= 1'b0;
		end else if (i_bus_reset) begin
			trig_q <= 1'b0;
		end else if (wr_ctrl && i_wdata[CTRL_TRIG_BIT]) begin
			trig_q <= 1'b1;
		end
	end

	// initiator is latched at each bus reset, and software may overwrite it
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_q <= 1'b0;
		end else if (i_bus_reset) begin
			init_q <= i_reset_by_us || trig_q;
		end else if (wr_stat) begin
			init_q <= i_wdata[STAT_INIT_BIT];
		end
	end

	// root request is untouched by bus reset
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rreq_q <= 1'b0;
		end else if (wr_ctrl) begin
			rreq_q <= i_wdata[CTRL_RREQ_BIT];
		end
	end

	// ****************************************
	// loop timeout and root
	// ****************************************
	logic loop_q;
	logic root_q;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_q <= 1'b0;
		end else if (i_loop_timeout) begin
			loop_q <= 1'b1;
		end else if (wr_stat && !i_wdata[STAT_LOOP_BIT]) begin
			loop_q <= 1'b0;
		end
	end

	// becoming root during tree identification outranks the reset that began it
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			root_q <= 1'b0;
		end else if (i_became_root) begin
			root_q <= 1'b1;
		end else if (i_bus_reset) begin
			root_q <= 1'b0;
		end
	end

	// ****************************************
	// connection debounce
	// ****************************************
	logic [NUM_PORTS-1:0] conn_q;
	logic [31:0] deb_cnt_q [NUM_PORTS];

	// a connect must hold for the full count; a disconnect drops at once
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			conn_q <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				deb_cnt_q[p] <= 32'h0;
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (!i_port_raw[p]) begin
					conn_q[p] <= 1'b0;
					deb_cnt_q[p] <= 32'h0;
				end else if (!conn_q[p]) begin
					if (deb_cnt_q[p] >= 32'(DEBOUNCE_CYCLES - 1)) begin
						conn_q[p] <= 1'b1;
					end else begin
						deb_cnt_q[p] <= deb_cnt_q[p] + 32'h1;
					end
				end
			end
		end
	end

	// ****************************************
	// register 0 image and self-id status
	// ****************************************
	logic [7:0] reg0;

	// each field placed at its named bit so the map lives in the package alone
	always_comb begin
		reg0 = 8'h00;
		reg0[ID_ADDR_LSB +: 6] = i_node_address;
		reg0[ID_ROOT_BIT] = root_q;
		reg0[ID_CPL_BIT] = i_cable_power;
	end

	logic st_valid_q;
	logic [7:0] st_data_q;

	// completion of self-id pushes register 0 out unasked
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_valid_q <= 1'b0;
			st_data_q <= 8'h00;
		end else begin
			st_valid_q <= i_selfid_done;
			if (i_selfid_done) begin
				st_data_q <= reg0;
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	logic [IRQ_W-1:0] irq_st_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [IRQ_W-1:0] irq_ev;

	// event vector in status bit order; every event is a one-cycle pulse
	// a drop flag re-set while the sense stays low raises no new status, only a fresh fall
	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_CPD_BIT] = cp_fall;
		irq_ev[IRQ_LOOP_BIT] = i_loop_timeout;
		irq_ev[IRQ_SELFID_BIT] = i_selfid_done;
	end

	// new events win over a clear in the same cycle
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_st_q <= '0;
		end else begin
			irq_st_q <= (irq_st_q & ~(wr_clr ? i_wdata[IRQ_W-1:0] : '0)) | irq_ev;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_q <= '0;
		end else if (wr_en) begin
			irq_en_q <= i_wdata[IRQ_W-1:0];
		end
	end

	// ****************************************
	// read data, one cycle after the strobe
	// ****************************************
	logic [7:0] rd_d;
	logic [7:0] ctrl_img;
	logic [7:0] cap_img;
	logic [7:0] stat_img;

	// control image: root request, trigger, gap count
	always_comb begin
		ctrl_img = 8'h00;
		ctrl_img[CTRL_RREQ_BIT] = rreq_q;
		ctrl_img[CTRL_TRIG_BIT] = trig_q;
		ctrl_img[CTRL_GAP_LSB +: 6] = gap_q;
	end

	// capability image: all constants, so writes to it have nothing to land on
	always_comb begin
		cap_img = 8'h00;
		cap_img[CAP_SPEED_LSB +: 2] = SPEED_CAP;
		cap_img[CAP_PORTS_LSB +: 4] = PORT_COUNT;
		cap_img[CAP_REV_LSB +: 2] = REVISION;
	end

	// status image: the cable power level shows here a second time
	always_comb begin
		stat_img = 8'h00;
		stat_img[STAT_CPD_BIT] = cpd_q;
		stat_img[STAT_LOOP_BIT] = loop_q;
		stat_img[STAT_INIT_BIT] = init_q;
		stat_img[STAT_CPL_BIT] = i_cable_power;
	end

	always_comb begin
		rd_d = 8'h00;
		case (i_addr)
			ADDR_ID: rd_d = reg0;
			ADDR_CTRL: rd_d = ctrl_img;
			ADDR_CAP: rd_d = cap_img;
			ADDR_STAT: rd_d = stat_img;
			ADDR_PORT: rd_d = 8'(conn_q);
			ADDR_IRQ_ST: rd_d = 8'(irq_st_q);
			ADDR_IRQ_EN: rd_d = 8'(irq_en_q);
			default: rd_d = 8'h00; // unmapped and write-only read zero
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rd_d;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_start_reset = trig_q;
	assign o_root_request = rreq_q;
	assign o_gap_count = gap_q;
	assign o_initiator = init_q;
	assign o_port_connected = conn_q;
	assign o_status_valid = st_valid_q;
	assign o_status_data = st_data_q;
	assign o_irq = |(irq_st_q & irq_en_q);
endmodule // phy_regs

// file: src/phy_regs_pkg.sv
// constants for the serial bus phy configuration and status register bank
package phy_regs_pkg;
	// register indices on the plain port (byte-free word addresses)
	localparam logic [3:0] ADDR_ID = 4'h0;      // node address, root, cable power
	localparam logic [3:0] ADDR_CTRL = 4'h1;    // root request, trigger, gap count
	localparam logic [3:0] ADDR_CAP = 4'h2;     // speed, port count, revision
	localparam logic [3:0] ADDR_STAT = 4'h3;    // flags, initiator, cable power copy
	localparam logic [3:0] ADDR_PORT = 4'h4;    // port connection status
	localparam logic [3:0] ADDR_IRQ_ST = 4'h5;  // sticky interrupt status
	localparam logic [3:0] ADDR_IRQ_CLR = 4'h6; // write 1 to clear
	localparam logic [3:0] ADDR_IRQ_EN = 4'h7;  // interrupt enable
	// field positions
	localparam int ID_ADDR_LSB = 2;
	localparam int ID_ROOT_BIT = 1;
	localparam int ID_CPL_BIT = 0;
	localparam int CTRL_RREQ_BIT = 7;
	localparam int CTRL_TRIG_BIT = 6;
	localparam int CTRL_GAP_LSB = 0;
	localparam int CAP_SPEED_LSB = 6;
	localparam int CAP_PORTS_LSB = 2;
	localparam int CAP_REV_LSB = 0;
	localparam int STAT_CPD_BIT = 3;
	localparam int STAT_LOOP_BIT = 2;
	localparam int STAT_INIT_BIT = 1;
	localparam int STAT_CPL_BIT = 0;
	localparam int IRQ_CPD_BIT = 0;
	localparam int IRQ_LOOP_BIT = 1;
	localparam int IRQ_SELFID_BIT = 2;
	localparam int IRQ_W = 3;
	// reset and constant values
	localparam logic [5:0] GAP_RESET = 6'h3f;
	localparam logic [3:0] PORT_COUNT = 4'h3;
	localparam logic [1:0] SPEED_CAP = 2'h1;
	localparam logic [1:0] REVISION_DEFAULT = 2'h2; // arbitrary value
	// connection debounce
	localparam longint DEBOUNCE_MS = 335;
	localparam longint CLK_HZ = 200000000;
	localparam longint DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
endpackage

// file: testbench/llc_model.sv
// link-layer controller model on the register port
`timescale 1ns/1ps
module llc_model (
	// clock and read data
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	// strobes, address, data
	output logic [3:0] o_addr = 4'h0,
	output logic [7:0] o_wdata = 8'h00,
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0
);
	// ******
	// access
	// ******
	// idle bus shows inverted values so a stale field cannot pass
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask
endmodule // llc_model

// file: testbench/phy_regs_asserts.sv
// assertions on the phy register bank ports
`timescale 1ns/1ps
module phy_regs_asserts
	import phy_regs_pkg::*;
#(
	parameter logic [1:0] REVISION = REVISION_DEFAULT
) (
	// clock, reset, register port
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// core side
	input wire logic i_bus_reset,
	input wire logic i_cfg_gap_valid,
	input wire logic [5:0] i_cfg_gap,
	input wire logic o_start_reset,
	input wire logic o_root_request,
	input wire logic [5:0] o_gap_count
);
	// ******
	// checks
	// ******
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic cw;
	logic armed_q;
	assign cw = i_wr && i_addr == ADDR_CTRL;
	// a bus reset with no gap update since; the next one must restore the gap
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			armed_q <= 1'b0;
		end else if (cw || i_cfg_gap_valid || i_bus_reset) begin
			armed_q <= i_bus_reset && !cw && !i_cfg_gap_valid;
		end
	end
	property p_trig_set;
		cw && i_wdata[CTRL_TRIG_BIT] && !i_bus_reset |=> o_start_reset;
	endproperty
	a_trig_set: assert property (p_trig_set) else $error("no reset start");
	property p_trig_clr;
		i_bus_reset && !cw |=> !o_start_reset;
	endproperty
	a_trig_clr: assert property (p_trig_clr) else $error("trigger kept");
	property p_gap_wr;
		cw |=> o_gap_count == $past(i_wdata[5:0]);
	endproperty
	a_gap_wr: assert property (p_gap_wr) else $error("gap write lost");
	property p_gap_cfg;
		i_cfg_gap_valid && !cw |=> o_gap_count == $past(i_cfg_gap);
	endproperty
	a_gap_cfg: assert property (p_gap_cfg) else $error("gap packet lost");
	property p_gap_rst;
		i_bus_reset && armed_q && !cw && !i_cfg_gap_valid |=> o_gap_count == GAP_RESET;
	endproperty
	a_gap_rst: assert property (p_gap_rst) else $error("gap not restored");
	property p_rreq_wr;
		cw |=> o_root_request == $past(i_wdata[CTRL_RREQ_BIT]);
	endproperty
	a_rreq_wr: assert property (p_rreq_wr) else $error("root request lost");
	// bus resets included: only a write may move the request
	property p_rreq_keep;
		!cw [*2] |-> $stable(o_root_request);
	endproperty
	a_rreq_keep: assert property (p_rreq_keep) else $error("root request moved");
	property p_cap;
		i_rd && i_addr == ADDR_CAP |=> o_rdata == {SPEED_CAP, PORT_COUNT, REVISION};
	endproperty
	a_cap: assert property (p_cap) else $error("bad capability");
	c_restore: cover property (i_bus_reset && armed_q);
	c_trig: cover property (cw && i_wdata[CTRL_TRIG_BIT]);
	c_cfg: cover property (i_cfg_gap_valid);
endmodule // phy_regs_asserts

// file: testbench/tb.sv
// self-checking bench for the phy register bank
`timescale 1ns/1ps
bind phy_regs phy_regs_asserts #(.REVISION(REVISION)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_bus_reset(i_bus_reset), .i_cfg_gap_valid(i_cfg_gap_valid), .i_cfg_gap(i_cfg_gap),
	.o_start_reset(o_start_reset), .o_root_request(o_root_request), .o_gap_count(o_gap_count));
module tb;
	import phy_regs_pkg::*;
	logic clk, rst_n, cp, by_us, wr, rd, start, irq, sval, init;
	logic [4:0] evs;
	logic [3:0] addr;
	logic [5:0] gap_in, gap;
	logic [7:0] wdata, rdata, sdata;
	logic [2:0] praw, conn;
	int n_errors = 0;
	int num_checks = 0;
	phy_regs #(.DEBOUNCE_CYCLES(10)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cable_power(cp),
		.i_bus_reset(evs[4]), .i_reset_by_us(by_us), .i_loop_timeout(evs[3]),
		.i_became_root(evs[2]), .i_selfid_done(evs[1]), .i_node_address(6'h15),
		.i_cfg_gap_valid(evs[0]), .i_cfg_gap(gap_in), .i_port_raw(praw),
		.o_start_reset(start), .o_root_request(), .o_gap_count(gap), .o_initiator(init),
		.o_port_connected(conn), .o_status_valid(sval), .o_status_data(sdata), .o_irq(irq));
	llc_model u_llc (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
		.o_rd(rd));
	// *****
	// tasks
	// *****
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_llc.rd(a, d);
		chk(d, e);
	endtask
	// one-cycle event: 0 bus reset, 1 loop, 2 root, 3 self-id, 4 gap packet
	task automatic ev(input int k);
		@(posedge clk);
		evs <= 5'h10 >> k;
		@(posedge clk);
		evs <= 5'h00;
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// the run needs about 150 cycles
	initial begin
		#10000;
		n_errors++;
		end_sim();
	end
	// *****
	// tests
	// *****
	initial begin
		{rst_n, cp, by_us, evs, gap_in, praw} = {3'h2, 5'h00, 6'h11, 3'h0};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc(ADDR_ID, 8'h55);
		rc(ADDR_CTRL, {2'h0, GAP_RESET});
		u_llc.wr(ADDR_CAP, 8'h00);
		rc(ADDR_CAP, {SPEED_CAP, PORT_COUNT, REVISION_DEFAULT});
		rc(4'hf, 8'h00);
		$display("reset test done");
		u_llc.wr(ADDR_IRQ_EN, 8'h01);
		cp <= 1'b0;
		repeat (4) @(posedge clk);
		rc(ADDR_STAT, 8'h08);
		rc(ADDR_ID, 8'h54);
		chk({7'h0, irq}, 8'h01);
		u_llc.wr(ADDR_IRQ_EN, 8'h00);
		@(negedge clk) chk({7'h0, irq}, 8'h00);
		u_llc.wr(ADDR_STAT, 8'h00);
		rc(ADDR_STAT, 8'h08);
		@(posedge clk) cp <= 1'b1;
		u_llc.wr(ADDR_STAT, 8'h08);
		rc(ADDR_STAT, 8'h09);
		u_llc.wr(ADDR_STAT, 8'h00);
		rc(ADDR_STAT, 8'h01);
		u_llc.wr(ADDR_IRQ_EN, 8'h01);
		u_llc.wr(ADDR_IRQ_CLR, 8'h01);
		@(negedge clk) chk({7'h0, irq}, 8'h00);
		$display("cable power test done");
		ev(1);
		rc(ADDR_STAT, 8'h05);
		u_llc.wr(ADDR_STAT, 8'h04);
		rc(ADDR_STAT, 8'h05);
		u_llc.wr(ADDR_STAT, 8'h00);
		rc(ADDR_STAT, 8'h01);
		// twice a five-hop bus
		u_llc.wr(ADDR_CTRL, 8'h8a);
		@(negedge clk) chk({2'h0, gap}, 8'h0a);
		ev(0);
		rc(ADDR_CTRL, 8'h8a);
		ev(0);
		rc(ADDR_CTRL, 8'hbf);
		ev(0);
		ev(4);
		ev(0);
		rc(ADDR_CTRL, 8'h91);
		ev(0);
		rc(ADDR_CTRL, 8'hbf);
		$display("gap test done");
		u_llc.wr(ADDR_CTRL, 8'h7f);
		@(negedge clk) chk({7'h0, start}, 8'h01);
		by_us <= 1'b1;
		ev(0);
		@(negedge clk) chk({7'h0, start}, 8'h00);
		chk({7'h0, init}, 8'h01);
		rc(ADDR_CTRL, 8'h3f);
		rc(ADDR_STAT, 8'h03);
		by_us <= 1'b0;
		ev(2);
		rc(ADDR_ID, 8'h57);
		ev(0);
		rc(ADDR_ID, 8'h55);
		rc(ADDR_STAT, 8'h01);
		chk({7'h0, init}, 8'h00);
		ev(3);
		@(negedge clk) chk({sval, 7'h0}, 8'h80);
		chk(sdata, 8'h55);
		rc(ADDR_IRQ_ST, 8'h06);
		rc(ADDR_IRQ_EN, 8'h01);
		$display("reset and root test done");
		praw <= 3'h5;
		repeat (5) @(posedge clk);
		@(negedge clk) chk({5'h0, conn}, 8'h00);
		repeat (12) @(posedge clk);
		rc(ADDR_PORT, 8'h05);
		@(posedge clk) praw <= 3'h1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk({5'h0, conn}, 8'h01);
		u_llc.wr(ADDR_CTRL, 8'hc5);
		ev(1);
		@(posedge clk) rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc(ADDR_CTRL, 8'h3f);
		rc(ADDR_STAT, 8'h01);
		$display("port and second reset test done");
		end_sim();
	end
endmodule // tb
